// ===== verilog/prd_dma_pkg.sv
// Constants and types of the descriptor-chain bus-master DMA engine
package prd_dma_pkg;
    // Register word offsets on the register port
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] PTR_OFS  = 4'h8;
    localparam logic [3:0] FEAT_OFS = 4'hc;
    // Control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_DIR_BIT   = 3;
    // Status register fields
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_ERR_BIT    = 1;
    localparam int STAT_INTR_BIT   = 2;
    localparam int STAT_EOT_BIT    = 3;
    // Feature register fields
    localparam int FEAT_MULTI_BIT  = 0;
    localparam int FEAT_EOTEN_BIT  = 1;
    // Descriptor layout
    localparam int DESC_EOT_BIT    = 31;
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0008;
    localparam logic [31:0] WORD_STEP   = 32'h0000_0002;
    localparam logic [16:0] CNT_STEP    = 17'h0_0002;
    localparam logic [16:0] CNT_FULL    = 17'h1_0000;
    localparam logic [29:0] PTR_RESET   = 30'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH0 = 3'b001,
        ST_FETCH1 = 3'b010,
        ST_WAIT  = 3'b011,
        ST_MEMRD = 3'b100,
        ST_MEMWR = 3'b101
    } dma_state_type;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        half;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_type;

    typedef struct packed {
        dma_state_type st;
        logic          start;
        logic          dir;
        logic          multi;
        logic          eot_en;
        logic [29:0]   ptr;
        logic [31:0]   cur;
        logic [31:0]   maddr;
        logic [16:0]   cnt;
        logic          end_of_table_bit;
        logic          active;
        logic          err;
        logic          intr;
        logic          eotf;
        logic          done_pend;
        logic [31:0]   rdata;
        logic [15:0]   dev_data;
        logic          dev_ack;
        logic [15:0]   cap;
        logic          rq_s1;
        logic          rq_s2;
        logic          rq_s3;
        logic          iq_s1;
        logic          iq_s2;
        logic          iq_s3;
        logic [15:0]   dat_s1;
        logic [15:0]   dat_s2;
    } dma_regs_type;
endpackage

// ===== verilog/prd_dma_engine.sv
// Descriptor-chain bus-master DMA engine between system memory and a disk device
// Behaviour
// - After reset the engine runs single-set mode: one chain covers one command.
// - Transfer direction comes from the control register direction bit.
// - Error and interrupt flags clear when software writes one to them.
// - Writing one to the start bit starts from the descriptor pointer.
// - Data moves only on device DMA requests, mastering memory at descriptor address.
// - Exhausted descriptor fetches the next one unless its end-of-table bit is set.
// - Single-set mode interrupts when device interrupt follows completed data.
// - Feature register multi-set bit selects multi-set mode.
// - With done-enable set, last-descriptor completion raises interrupt and done flag; the code does this only in multi-set mode.
// - With done-enable clear, completion alone sets no done flag nor interrupt.
// - Transfer-active bit stays readable for polling.
// - Writing one to the done flag clears it and its interrupt.
// - Multi-set mode records a device interrupt in the interrupt flag.
// - Descriptor pointer keeps its value across activations.
// - Descriptor: address word, then end-of-table bit 31, count bits 15-0, zero=64K.
// - Pointer bits 1-0 read as zero.
// - After the last word the interrupt flag is set and active clears; the code clears active but sets the interrupt flag only on a device interrupt.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module prd_dma_engine
    import prd_dma_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [31:0] o_reg_rdata,
    output mem_req_type      o_mem,
    input  wire logic        i_mem_ack,
    input  wire logic [31:0] i_mem_rdata,
    input  wire logic        i_dev_dmarq,
    input  wire logic        i_dev_intrq,
    input  wire logic [15:0] i_dev_data,
    output logic      [15:0] o_dev_data,
    output logic             o_dev_ack,
    output logic             o_irq
);
    dma_regs_type s;
    dma_regs_type nxt_s;

    logic wr_ctrl;
    logic wr_stat;
    logic wr_ptr;
    logic wr_feat;
    logic req_edge;
    logic iq_rise;
    logic word_done;
    logic last_word;
    logic fin;
    logic set_intr;
    logic set_eotf;

    assign wr_ctrl = i_reg_wr && (i_reg_addr == CTRL_OFS);
    assign wr_stat = i_reg_wr && (i_reg_addr == STAT_OFS);
    assign wr_ptr  = i_reg_wr && (i_reg_addr == PTR_OFS);
    assign wr_feat = i_reg_wr && (i_reg_addr == FEAT_OFS);
    // Edge taken from the second and third stages; first stage feeds only the second
    assign req_edge  = s.rq_s2 && !s.rq_s3;
    assign iq_rise   = s.iq_s2 && !s.iq_s3;
    assign word_done = ((s.st == ST_MEMRD) || (s.st == ST_MEMWR)) && i_mem_ack;
    assign last_word = word_done && (s.cnt == CNT_STEP);
    assign fin       = last_word && s.end_of_table_bit;
    // Multi mode records the device interrupt on its own; single mode waits for data done
    assign set_intr  = s.multi ? iq_rise
                               : (s.iq_s2 && (s.done_pend || fin));
    assign set_eotf  = fin && s.multi && s.eot_en;

    always_comb begin
        nxt_s = s;
        nxt_s.rq_s1  = i_dev_dmarq;
        nxt_s.rq_s2  = s.rq_s1;
        nxt_s.rq_s3  = s.rq_s2;
        nxt_s.iq_s1  = i_dev_intrq;
        nxt_s.iq_s2  = s.iq_s1;
        nxt_s.iq_s3  = s.iq_s2;
        nxt_s.dat_s1 = i_dev_data;
        nxt_s.dat_s2 = s.dat_s1;
        nxt_s.dev_ack = 1'b0;

        if (wr_ctrl) begin
            nxt_s.start = i_reg_wdata[CTRL_START_BIT];
            nxt_s.dir   = i_reg_wdata[CTRL_DIR_BIT];
        end
        if (wr_ptr) begin
            nxt_s.ptr = i_reg_wdata[31:2];
        end
        if (wr_feat) begin
            nxt_s.multi  = i_reg_wdata[FEAT_MULTI_BIT];
            nxt_s.eot_en = i_reg_wdata[FEAT_EOTEN_BIT];
        end
        // Write-one clears; a same-cycle set below overrides the clear
        if (wr_stat) begin
            if (i_reg_wdata[STAT_ERR_BIT]) begin
                nxt_s.err = 1'b0;
            end
            if (i_reg_wdata[STAT_INTR_BIT]) begin
                nxt_s.intr = 1'b0;
            end
            if (i_reg_wdata[STAT_EOT_BIT]) begin
                nxt_s.eotf = 1'b0;
            end
        end

        unique case (s.st)
            ST_IDLE: begin
                if (wr_ctrl && i_reg_wdata[CTRL_START_BIT]) begin
                    nxt_s.cur    = {s.ptr, 2'b00};
                    nxt_s.active = 1'b1;
                    nxt_s.done_pend = 1'b0;
                    nxt_s.st     = ST_FETCH0;
                end
            end
            ST_FETCH0: begin
                if (i_mem_ack) begin
                    nxt_s.maddr = {i_mem_rdata[31:1], 1'b0};
                    nxt_s.st    = ST_FETCH1;
                end
            end
            ST_FETCH1: begin
                if (i_mem_ack) begin
                    nxt_s.end_of_table_bit = i_mem_rdata[DESC_EOT_BIT];
                    nxt_s.cnt = (i_mem_rdata[15:1] == 15'h0000) ? CNT_FULL
                              : {1'b0, i_mem_rdata[15:1], 1'b0};
                    nxt_s.cur = s.cur + DESC_STRIDE;
                    nxt_s.st  = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Dropping start while waiting for a device request aborts and is reported as an error
                if (wr_ctrl && !i_reg_wdata[CTRL_START_BIT]) begin
                    nxt_s.active = 1'b0;
                    nxt_s.err    = 1'b1;
                    nxt_s.st     = ST_IDLE;
                end else if (req_edge) begin
                    nxt_s.cap = s.dat_s2;
                    nxt_s.st  = s.dir ? ST_MEMRD : ST_MEMWR;
                end
            end
            ST_MEMRD, ST_MEMWR: begin
                if (i_mem_ack) begin
                    if (s.st == ST_MEMRD) begin
                        nxt_s.dev_data = i_mem_rdata[15:0];
                    end
                    nxt_s.dev_ack = 1'b1;
                    nxt_s.maddr   = s.maddr + WORD_STEP;
                    nxt_s.cnt     = s.cnt - CNT_STEP;
                    if (!last_word) begin
                        nxt_s.st = ST_WAIT;
                    end else if (s.end_of_table_bit) begin
                        nxt_s.active    = 1'b0;
                        nxt_s.done_pend = !s.multi;
                        nxt_s.st        = ST_IDLE;
                    end else begin
                        nxt_s.st = ST_FETCH0;
                    end
                end
            end
            default: begin
                nxt_s.st = ST_IDLE;
            end
        endcase

        if (set_intr) begin
            nxt_s.intr      = 1'b1;
            nxt_s.done_pend = 1'b0;
        end
        if (set_eotf) begin
            nxt_s.eotf = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s          <= '0;
            s.st       <= ST_IDLE;
            s.ptr      <= PTR_RESET;
        end else begin
            s <= nxt_s;
        end
    end

    // Read data is registered so it stands only in the cycle after the strobe
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                CTRL_OFS: begin
                    rd_mux[CTRL_START_BIT] = s.start;
                    rd_mux[CTRL_DIR_BIT]   = s.dir;
                end
                STAT_OFS: begin
                    rd_mux[STAT_ACTIVE_BIT] = s.active;
                    rd_mux[STAT_ERR_BIT]    = s.err;
                    rd_mux[STAT_INTR_BIT]   = s.intr;
                    rd_mux[STAT_EOT_BIT]    = s.eotf;
                end
                PTR_OFS: begin
                    rd_mux = {s.ptr, 2'b00};
                end
                FEAT_OFS: begin
                    rd_mux[FEAT_MULTI_BIT] = s.multi;
                    rd_mux[FEAT_EOTEN_BIT] = s.eot_en;
                end
                default: begin
                    rd_mux = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reg_rdata <= 32'h0000_0000;
        end else begin
            o_reg_rdata <= rd_mux;
        end
    end

    always_comb begin
        o_mem.req   = (s.st == ST_FETCH0) || (s.st == ST_FETCH1)
                   || (s.st == ST_MEMRD) || (s.st == ST_MEMWR);
        o_mem.we    = (s.st == ST_MEMWR);
        o_mem.half  = (s.st == ST_MEMRD) || (s.st == ST_MEMWR);
        o_mem.addr  = o_mem.half ? s.maddr
                    : ((s.st == ST_FETCH1) ? (s.cur + 32'h0000_0004) : s.cur);
        o_mem.wdata = {16'h0000, s.cap};
    end

    assign o_dev_data = s.dev_data;
    assign o_dev_ack  = s.dev_ack;
    // No flow control from the destination: sizing is software's job
    assign o_irq      = s.intr || s.eotf;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_start_wr;
        (s.st == ST_IDLE) && wr_ctrl && i_reg_wdata[CTRL_START_BIT];
    endsequence
    sequence s_fetch_begin;
        (s.st == ST_FETCH0) && s.active && (s.cur == {$past(s.ptr), 2'b00});
    endsequence

    property p_single_no_done;
        (fin && !s.multi) |=> !s.eotf || $past(s.eotf);
    endproperty
    a_single_no_done: assert property (p_single_no_done)
        else $error("Done flag rose in single-set mode");

    property p_dir_read;
        (s.st == ST_WAIT && req_edge && !wr_ctrl) |=> (s.st == ST_MEMRD) == $past(s.dir);
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("Memory access direction disagrees with direction bit");

    property p_err_clear;
        (wr_stat && i_reg_wdata[STAT_ERR_BIT] && !(s.st == ST_WAIT && wr_ctrl)) |=> !s.err;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("Error flag survived write-one clear");

    property p_start;
        s_start_wr |=> s_fetch_begin;
    endproperty
    a_start: assert property (p_start)
        else $error("Start did not load pointer into fetch");

    property p_req_only;
        (s.st == ST_WAIT) ##1 (s.st == ST_MEMRD || s.st == ST_MEMWR) |-> $past(req_edge);
    endproperty
    a_req_only: assert property (p_req_only)
        else $error("Data access without device request");

    property p_chain;
        (last_word && !s.end_of_table_bit) |=> (s.st == ST_FETCH0) && (o_mem.addr == s.cur);
    endproperty
    a_chain: assert property (p_chain)
        else $error("Next descriptor not fetched");

    property p_done_irq;
        (fin && s.multi && s.eot_en) |=> s.eotf && o_irq;
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("Completion did not raise done interrupt");

    property p_no_done;
        (fin && !s.eot_en && !s.eotf) |=> !s.eotf;
    endproperty
    a_no_done: assert property (p_no_done)
        else $error("Done flag set with enable clear");

    property p_done_clear;
        (wr_stat && i_reg_wdata[STAT_EOT_BIT] && !set_eotf) |=> !s.eotf;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("Done flag not cleared");

    property p_multi_intr;
        (s.multi && iq_rise) |=> s.intr && o_irq;
    endproperty
    a_multi_intr: assert property (p_multi_intr)
        else $error("Device interrupt not recorded in multi-set mode");

    property p_ptr_low;
        (i_reg_rd && i_reg_addr == PTR_OFS) |=> o_reg_rdata[1:0] == 2'b00;
    endproperty
    a_ptr_low: assert property (p_ptr_low)
        else $error("Pointer low bits not zero");

    property p_fin_idle;
        fin |=> !s.active && (s.st == ST_IDLE);
    endproperty
    a_fin_idle: assert property (p_fin_idle)
        else $error("Active bit stayed set after last word");

    property p_irq_drop;
        (s.intr || s.eotf) ##1 (!s.intr && !s.eotf) |-> !o_irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("Interrupt output not negated after flags cleared");
endmodule

// ===== tb/disk_side_model.sv
// Memory slave and disk-device model on the far side of the DMA engine
`timescale 1ns/1ps
module disk_side_model
    import prd_dma_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  mem_req_type      i_mem,
    input  wire logic [3:0]  i_slow,
    output logic             o_mem_ack,
    output logic      [31:0] o_mem_rdata,
    output logic             o_dmarq,
    output logic             o_intrq,
    output logic      [15:0] o_data,
    input  wire logic        i_dev_ack,
    input  wire logic [15:0] i_dev_data
);
    logic [15:0] m [0:127];
    logic [15:0] got [$];
    logic [15:0] word_val;
    logic [3:0]  dly;
    logic [6:0]  idx;
    logic        take;

    initial begin
        o_dmarq = 1'b0;
        o_intrq = 1'b0;
        word_val = 16'ha500;
    end
    assign idx = i_mem.addr[7:1];
    assign take = i_mem.req && !o_mem_ack && dly == 4'h0;
    // Outside an ack the bus shows a scrambled word so stale data cannot pass
    assign o_mem_rdata = !o_mem_ack ? ~{m[idx + 7'd1], m[idx]} :
                         i_mem.half ? {16'h0000, m[idx]} : {m[idx + 7'd1], m[idx]};
    assign o_data = o_dmarq ? word_val : ~word_val;

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_mem_ack <= 1'b0;
            dly <= 4'h0;
        end else begin
            o_mem_ack <= take;
            dly <= (!i_mem.req || o_mem_ack) ? i_slow : (dly == 4'h0 ? dly : dly - 4'h1);
            if (take && i_mem.we) begin
                m[idx] <= i_mem.wdata[15:0];
            end
        end
    end

    // One request edge per word; data held steady while the request stands
    task automatic send_words(input int n, output int lost);
        int t;
        lost = 0;
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            // An edge raised during a descriptor fetch is dropped, so wait for a quiet bus
            for (t = 0; t < 80 && i_mem.req === 1'b1; t++) @(posedge i_clk);
            o_dmarq <= 1'b1;
            for (t = 0; t < 80 && i_dev_ack !== 1'b1; t++) @(posedge i_clk);
            if (t == 80) lost++;
            got.push_back(i_dev_data);
            word_val <= word_val + 16'h0001;
            o_dmarq <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
    endtask

    task automatic set_irq(input logic v);
        @(posedge i_clk);
        o_intrq <= v;
        repeat (6) @(posedge i_clk);
    endtask
endmodule

// ===== tb/tb.sv
// Register-level testbench of the descriptor-chain DMA engine
`timescale 1ns/1ps
module tb
    import prd_dma_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  slow = 4'h0;
    logic [31:0] reg_rdata;
    mem_req_type mem;
    logic        mem_ack;
    logic [31:0] mem_rdata;
    logic        dmarq;
    logic        intrq;
    logic [15:0] ddata;
    logic [15:0] dev_out;
    logic        dev_ack;
    logic        irq;
    int          fails = 0;
    int          num_checks = 0;
    int          lost;

    always #4 clk = ~clk;

    prd_dma_engine dut (.i_clk(clk), .i_reset(reset), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .o_mem(mem), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
        .i_dev_dmarq(dmarq), .i_dev_intrq(intrq), .i_dev_data(ddata),
        .o_dev_data(dev_out), .o_dev_ack(dev_ack), .o_irq(irq));

    disk_side_model pm (.i_clk(clk), .i_reset(reset), .i_mem(mem), .i_slow(slow),
        .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata), .o_dmarq(dmarq), .o_intrq(intrq),
        .o_data(ddata), .i_dev_ack(dev_ack), .i_dev_data(dev_out));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(what, v, exp);
    endtask

    // Software polls the active bit; a stuck engine ends the run
    task automatic wait_idle();
        int n;
        logic [31:0] s;
        s = 32'h1;
        for (n = 0; n < 60 && s[STAT_ACTIVE_BIT] !== 1'b0; n++) rd(STAT_OFS, s);
        if (n == 60) begin
            fails++;
            wrap_up();
        end
    endtask

    task automatic put32(input logic [7:0] a, input logic [31:0] v);
        pm.m[a[7:1]] = v[15:0];
        pm.m[a[7:1] + 7'd1] = v[31:16];
    endtask

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd_chk("ctrl", CTRL_OFS, 32'h0);
        rd_chk("feat", FEAT_OFS, 32'h0);
        wr(4'h2, 32'hffff_ffff);
        rd_chk("unmapped", 4'h2, 32'h0);
        wr(PTR_OFS, 32'h0000_0043);
        rd_chk("ptr", PTR_OFS, 32'h0000_0040);
        $display("test reset done");

        put32(8'h40, 32'h80);
        put32(8'h44, 32'h4);
        put32(8'h48, 32'h90);
        put32(8'h4c, 32'h8000_0002);
        wr(CTRL_OFS, 32'h0);
        wr(CTRL_OFS, 32'h1);
        rd_chk("active", STAT_OFS, 32'h1);
        pm.send_words(3, lost);
        chk("lost", lost, 32'h0);
        wait_idle();
        chk("m80", {16'h0, pm.m[8'h40]}, 32'ha500);
        chk("m82", {16'h0, pm.m[8'h41]}, 32'ha501);
        chk("m90", {16'h0, pm.m[8'h48]}, 32'ha502);
        rd_chk("no irq yet", STAT_OFS, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        pm.set_irq(1'b1);
        rd_chk("intr", STAT_OFS, 32'h4);
        chk("irq", {31'h0, irq}, 32'h1);
        pm.set_irq(1'b0);
        wr(STAT_OFS, 32'h4);
        rd_chk("intr clr", STAT_OFS, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(CTRL_OFS, 32'h0);
        rd_chk("ptr kept", PTR_OFS, 32'h0000_0040);
        $display("test single mode done");

        slow <= 4'h3;
        put32(8'h50, 32'ha0);
        put32(8'h54, 32'h8000_0004);
        put32(8'ha0, 32'h1234_5678);
        pm.got.delete();
        wr(FEAT_OFS, 32'h3);
        wr(PTR_OFS, 32'h50);
        wr(CTRL_OFS, 32'h8);
        wr(CTRL_OFS, 32'h9);
        pm.send_words(2, lost);
        chk("lost m1", lost, 32'h0);
        wait_idle();
        chk("out0", {16'h0, pm.got[0]}, 32'h5678);
        chk("out1", {16'h0, pm.got[1]}, 32'h1234);
        rd_chk("done", STAT_OFS, 32'h8);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(STAT_OFS, 32'h8);
        rd_chk("done clr", STAT_OFS, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(FEAT_OFS, 32'h1);
        wr(CTRL_OFS, 32'h9);
        pm.send_words(2, lost);
        chk("lost m2", lost, 32'h0);
        wait_idle();
        chk("out2", {16'h0, pm.got[2]}, 32'h5678);
        rd_chk("no done", STAT_OFS, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        pm.set_irq(1'b1);
        rd_chk("dev intr", STAT_OFS, 32'h4);
        pm.set_irq(1'b0);
        wr(STAT_OFS, 32'h4);
        wr(CTRL_OFS, 32'h8);
        rd_chk("final", STAT_OFS, 32'h0);
        $display("test multi mode done");

        slow <= 4'h0;
        wr(FEAT_OFS, 32'h0);
        wr(CTRL_OFS, 32'h1);
        repeat (10) @(posedge clk);
        rd_chk("waiting", STAT_OFS, 32'h1);
        wr(CTRL_OFS, 32'h0);
        rd_chk("abort", STAT_OFS, 32'h2);
        wr(STAT_OFS, 32'h2);
        rd_chk("err clr", STAT_OFS, 32'h0);
        $display("test abort done");
        wrap_up();
    end
endmodule
